/* hdl/cpurf_defines.svh */
// Constants of the core register file: register indices, flag positions,
// reset values. Assumes inclusion by the register file module.
`ifndef CPURF_DEFINES_SVH
`define CPURF_DEFINES_SVH

// ************************************************************
// Register indices on the plain register port
// ************************************************************
`define CPURF_IDX_DATA_A 5'h00
`define CPURF_IDX_DATA_B 5'h01
`define CPURF_IDX_DATA_C 5'h02
`define CPURF_IDX_DATA_D 5'h03
`define CPURF_IDX_ADDR_0 5'h04
`define CPURF_IDX_ADDR_1 5'h05
`define CPURF_IDX_ADDR_2 5'h06
`define CPURF_IDX_ADDR_3 5'h07
`define CPURF_IDX_STATIC 5'h08
`define CPURF_IDX_FRAME 5'h09
`define CPURF_IDX_NEXTPC 5'h0a
`define CPURF_IDX_VECTBL 5'h0b
`define CPURF_IDX_USERSP 5'h0c
`define CPURF_IDX_IRQSP 5'h0d
`define CPURF_IDX_STATUS 5'h0e
`define CPURF_IDX_ACTSP 5'h0f

// ************************************************************
// Status word flag positions
// ************************************************************
`define CPURF_FLG_CARRY 0
`define CPURF_FLG_DEBUG 1
`define CPURF_FLG_ZERO 2
`define CPURF_FLG_SIGN 3
`define CPURF_FLG_STACKSEL 7

// ************************************************************
// Reset values and status write mask
// ************************************************************
`define CPURF_RST_WORD 32'h0000_0000
`define CPURF_RST_STATUS 32'h0000_0000
`define CPURF_STATUS_MASK 32'h0000_008f

`endif

/* hdl/cpurf_pkg.sv */
// Types shared by the core register file and its users.
// Assumes cpurf_defines.svh is visible on the include path.
package cpurf_pkg;

   // ************************************************************
   // Part select for data register writes
   // ************************************************************
   typedef enum logic [2:0] {
      CPURF_PART_WORD = 3'h0,
      CPURF_PART_LOHALF = 3'h1,
      CPURF_PART_HIHALF = 3'h2,
      CPURF_PART_BYTE0 = 3'h3,
      CPURF_PART_BYTE1 = 3'h4,
      CPURF_PART_BYTE2 = 3'h5,
      CPURF_PART_BYTE3 = 3'h6
   } cpurf_part_t;

endpackage

/* hdl/cpurf_core_regs.sv */
// Core general-purpose and control register file.
// Assumes the sequencer drives one port access per cycle, synchronous to clk.
//
// Contract
// RQ1 - Four 32-bit data registers, halves writable
// RQ2 - First two data registers also byte writable
// RQ3 - Four address registers supply address bases
// RQ4 - Static base register drives its base output
// RQ5 - Frame base register drives its base output
// RQ6 - Program counter holds next instruction address
// RQ7 - Vector table base register held
// RQ8 - Two stack pointers, flag bit 7 selects
// RQ9 - Software keeps stack pointers word aligned
// RQ10 - Status word holds condition and control flags
// RQ11 - Carry flag captures ALU carry out
// RQ12 - Software writes debug flag as zero
// RQ13 - Zero flag set when result zero
// RQ14 - Sign flag set when result negative
// RQ15 - Partial writes keep other bits
// RQ16 - Flag zero interrupt SP, one user SP
// RQ17 - Flags change only when updates enabled
//
// The implementer's own choices: the register addresses and the plain strobed port.
`include "cpurf_defines.svh"

module cpurf_core_regs #(
   parameter int DataWidth = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] regAddr,
   input wire logic [DataWidth-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire cpurf_pkg::cpurf_part_t regWrPart,
   output logic [DataWidth-1:0] regRdData,
   input wire logic [DataWidth-1:0] aluResult,
   input wire logic aluCarry,
   input wire logic aluCarryEn,
   input wire logic aluZsEn,
   input wire logic pcLoad,
   input wire logic [DataWidth-1:0] pcLoadValue,
   input wire logic pcAdvance,
   input wire logic [3:0] pcStep,
   input wire logic spLoad,
   input wire logic [DataWidth-1:0] spLoadValue,
   output logic [DataWidth-1:0] nextInstrAddr,
   output logic [DataWidth-1:0] stackPtr,
   output logic [DataWidth-1:0] staticBase,
   output logic [DataWidth-1:0] frameBase,
   output logic [DataWidth-1:0] vectorBase,
   output logic [DataWidth-1:0] addrBase0,
   output logic [DataWidth-1:0] addrBase1,
   output logic [DataWidth-1:0] addrBase2,
   output logic [DataWidth-1:0] addrBase3,
   output logic carryFlag,
   output logic zeroFlag,
   output logic signFlag,
   output logic userStackSel
);

   // ************************************************************
   // Functions
   // ************************************************************
   // Merge write data into one part of a word, others kept
   function automatic logic [31:0] mergePart(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input cpurf_pkg::cpurf_part_t part,
      input logic byteOk
   );
      logic [31:0] res;
      res = oldVal;
      unique case (part)
         cpurf_pkg::CPURF_PART_WORD: res = newVal;
         cpurf_pkg::CPURF_PART_LOHALF: res[15:0] = newVal[15:0]; // see RQ15
         cpurf_pkg::CPURF_PART_HIHALF: res[31:16] = newVal[15:0]; // see RQ1
         cpurf_pkg::CPURF_PART_BYTE0: if (byteOk) res[7:0] = newVal[7:0];
         cpurf_pkg::CPURF_PART_BYTE1: if (byteOk) res[15:8] = newVal[7:0];
         cpurf_pkg::CPURF_PART_BYTE2: if (byteOk) res[23:16] = newVal[7:0];
         cpurf_pkg::CPURF_PART_BYTE3: if (byteOk) res[31:24] = newVal[7:0];
         default: res = oldVal;
      endcase
      return res;
   endfunction

   // Port index match, shared by every single-register decode
   function automatic logic idxHit(
      input logic [4:0] addr,
      input logic [4:0] idx
   );
      return addr == idx;
   endfunction

   // Register group of an index: data, address, base or stack
   function automatic logic [2:0] idxGroup(
      input logic [4:0] addr
   );
      return addr[4:2];
   endfunction

   // Active stack pointer; the flag set picks the user pointer
   function automatic logic [31:0] spSelect(
      input logic userSel,
      input logic [31:0] userVal,
      input logic [31:0] irqVal
   );
      return userSel ? userVal : irqVal; // see RQ16
   endfunction

   // ************************************************************
   // Storage
   // ************************************************************
   logic [31:0] dataReg_r [4];
   logic [31:0] addrReg_r [4];
   logic [31:0] staticBase_r;
   logic [31:0] frameBase_r;
   logic [31:0] nextPc_r;
   logic [31:0] vectorBase_r;
   logic [31:0] userSp_r;
   logic [31:0] irqSp_r;
   logic [31:0] status_r;
   logic [31:0] rdData_r;

   // ************************************************************
   // Decode
   // ************************************************************
   wire logic wrData = regWrStb && (idxGroup(regAddr) == 3'h0);
   wire logic wrAddr = regWrStb && (idxGroup(regAddr) == 3'h1);
   wire logic wrStatic = regWrStb && idxHit(regAddr, `CPURF_IDX_STATIC);
   wire logic wrFrame = regWrStb && idxHit(regAddr, `CPURF_IDX_FRAME);
   wire logic wrPc = regWrStb && idxHit(regAddr, `CPURF_IDX_NEXTPC);
   wire logic wrVec = regWrStb && idxHit(regAddr, `CPURF_IDX_VECTBL);
   wire logic wrUsp = regWrStb && idxHit(regAddr, `CPURF_IDX_USERSP);
   wire logic wrIsp = regWrStb && idxHit(regAddr, `CPURF_IDX_IRQSP);
   wire logic wrStatus = regWrStb && idxHit(regAddr, `CPURF_IDX_STATUS);
   wire logic wrActSp = regWrStb && idxHit(regAddr, `CPURF_IDX_ACTSP);
   wire logic [1:0] sel = regAddr[1:0];
   // Byte parts exist only on the first two data registers
   wire logic byteOk = (sel[1] == 1'b0); // see RQ2

   wire logic useUser = status_r[`CPURF_FLG_STACKSEL]; // see RQ16
   // Loads and active-pointer writes go to whichever pointer the flag selects
   wire logic spWr = spLoad || wrActSp;
   wire logic [31:0] spVal = spLoad ? spLoadValue : regWrData;

   wire logic [31:0] zero32 = 32'h0000_0000;
   wire logic resZero = (aluResult == zero32);
   wire logic resNeg = aluResult[31];

   // ************************************************************
   // Data and address registers
   // ************************************************************
   wire logic [31:0] dataWord_nxt = mergePart(dataReg_r[sel], regWrData,
      regWrPart, byteOk); // see RQ1

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) begin
            dataReg_r[i] <= `CPURF_RST_WORD;
         end
      end else if (wrData) begin
         dataReg_r[sel] <= dataWord_nxt; // see RQ1
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) begin
            addrReg_r[i] <= `CPURF_RST_WORD;
         end
      end else if (wrAddr) begin
         addrReg_r[sel] <= regWrData; // see RQ3
      end
   end

   // ************************************************************
   // Bases
   // ************************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         staticBase_r <= `CPURF_RST_WORD;
      end else if (wrStatic) begin
         staticBase_r <= regWrData; // see RQ4
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frameBase_r <= `CPURF_RST_WORD;
      end else if (wrFrame) begin
         frameBase_r <= regWrData; // see RQ5
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vectorBase_r <= `CPURF_RST_WORD;
      end else if (wrVec) begin
         vectorBase_r <= regWrData; // see RQ7
      end
   end

   // ************************************************************
   // Program counter
   // ************************************************************
   // Load wins over a port write, which wins over the step
   wire logic [31:0] pcStep32 = {28'h0000000, pcStep};
   wire logic [31:0] pcSum = nextPc_r + pcStep32;
   wire logic [31:0] nextPc_nxt = pcLoad ? pcLoadValue :
      wrPc ? regWrData :
      pcAdvance ? pcSum : nextPc_r; // see RQ6

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nextPc_r <= `CPURF_RST_WORD;
      end else begin
         nextPc_r <= nextPc_nxt; // see RQ6
      end
   end

   // ************************************************************
   // Stack pointers
   // ************************************************************
   // Alignment is left to software; low bits are stored as written
   wire logic [31:0] userSp_nxt = wrUsp ? regWrData :
      (spWr && useUser) ? spVal : userSp_r; // see RQ16
   wire logic [31:0] irqSp_nxt = wrIsp ? regWrData :
      (spWr && !useUser) ? spVal : irqSp_r; // see RQ16

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         userSp_r <= `CPURF_RST_WORD;
      end else begin
         userSp_r <= userSp_nxt; // see RQ8
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irqSp_r <= `CPURF_RST_WORD;
      end else begin
         irqSp_r <= irqSp_nxt; // see RQ8
      end
   end

   // ************************************************************
   // Status word
   // ************************************************************
   logic [31:0] status_nxt;
   always_comb begin
      status_nxt = status_r;
      if (wrStatus) begin
         // Debug bit is stored as written; software keeps it zero
         status_nxt = regWrData & `CPURF_STATUS_MASK; // see RQ10
      end
      // ALU updates win over a same-cycle port write
      if (aluCarryEn) begin
         status_nxt[`CPURF_FLG_CARRY] = aluCarry; // see RQ11
      end
      if (aluZsEn) begin
         status_nxt[`CPURF_FLG_ZERO] = resZero; // see RQ13
         status_nxt[`CPURF_FLG_SIGN] = resNeg; // see RQ14
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_r <= `CPURF_RST_STATUS;
      end else begin
         status_r <= status_nxt; // see RQ17
      end
   end

   // ************************************************************
   // Active stack pointer
   // ************************************************************
   // Registered copy so the pointer output comes straight from a flop
   logic [31:0] stackPtr_r;
   wire logic [31:0] stackPtr_nxt =
      spSelect(status_nxt[`CPURF_FLG_STACKSEL], userSp_nxt, irqSp_nxt);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stackPtr_r <= `CPURF_RST_WORD;
      end else begin
         stackPtr_r <= stackPtr_nxt; // see RQ16
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (idxGroup(regAddr))
         3'h0: rdMux = dataReg_r[sel];
         3'h1: rdMux = addrReg_r[sel];
         3'h2: begin
            unique case (sel)
               2'h0: rdMux = staticBase_r;
               2'h1: rdMux = frameBase_r;
               2'h2: rdMux = nextPc_r;
               2'h3: rdMux = vectorBase_r;
            endcase
         end
         3'h3: begin
            unique case (sel)
               2'h0: rdMux = userSp_r;
               2'h1: rdMux = irqSp_r;
               2'h2: rdMux = status_r;
               2'h3: rdMux = spSelect(useUser, userSp_r, irqSp_r);
            endcase
         end
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData_r <= `CPURF_RST_WORD;
      end else if (regRdStb) begin
         rdData_r <= rdMux;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign regRdData = rdData_r;
   assign nextInstrAddr = nextPc_r;
   assign stackPtr = stackPtr_r; // see RQ8
   assign staticBase = staticBase_r;
   assign frameBase = frameBase_r;
   assign vectorBase = vectorBase_r;
   assign addrBase0 = addrReg_r[0];
   assign addrBase1 = addrReg_r[1];
   assign addrBase2 = addrReg_r[2];
   assign addrBase3 = addrReg_r[3];
   assign carryFlag = status_r[`CPURF_FLG_CARRY];
   assign zeroFlag = status_r[`CPURF_FLG_ZERO];
   assign signFlag = status_r[`CPURF_FLG_SIGN];
   assign userStackSel = useUser;

endmodule // cpurf_core_regs

/* dv/cpurf_core_regs_chk.sv */
// Port checker for the core register file.
// Assumes one clock domain and binding onto cpurf_core_regs.
module cpurf_core_regs_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [31:0] regRdData,
   input wire logic [31:0] aluResult,
   input wire logic aluCarry,
   input wire logic aluCarryEn,
   input wire logic aluZsEn,
   input wire logic pcLoad,
   input wire logic [31:0] pcLoadValue,
   input wire logic pcAdvance,
   input wire logic [3:0] pcStep,
   input wire logic spLoad,
   input wire logic [31:0] spLoadValue,
   input wire logic [31:0] nextInstrAddr,
   input wire logic [31:0] stackPtr,
   input wire logic [31:0] staticBase,
   input wire logic carryFlag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   wire statWr = regWrStb && regAddr == 5'h0e;
   sequence s_pcRead;
      regRdStb && regAddr == 5'h0a;
   endsequence
   sequence s_sbWrite;
      regWrStb && regAddr == 5'h08;
   endsequence
   property p_pcRead;
      s_pcRead |=> regRdData == $past(nextInstrAddr);
   endproperty
   property p_sbWrite;
      s_sbWrite |=> staticBase == $past(regWrData);
   endproperty
   property p_sbKeep;
      !(regWrStb && regAddr == 5'h08) |=> $stable(staticBase);
   endproperty
   property p_carry;
      aluCarryEn |=> carryFlag == $past(aluCarry);
   endproperty
   property p_carryKeep;
      !aluCarryEn && !statWr |=> $stable(carryFlag);
   endproperty
   property p_pcLoad;
      pcLoad |=> nextInstrAddr == $past(pcLoadValue);
   endproperty
   property p_pcStep;
      pcAdvance && !pcLoad && !(regWrStb && regAddr == 5'h0a)
         |=> nextInstrAddr == $past(nextInstrAddr) + 32'($past(pcStep));
   endproperty
   property p_spLoad;
      spLoad && !regWrStb |=> stackPtr == $past(spLoadValue);
   endproperty
   property p_pcKeep;
      !pcLoad && !pcAdvance && !regWrStb |=> $stable(nextInstrAddr);
   endproperty
   a_pcRead: assert property (p_pcRead) else $error("pc read");
   a_sbWrite: assert property (p_sbWrite) else $error("sb");
   a_sbKeep: assert property (p_sbKeep) else $error("sb kept");
   a_carry: assert property (p_carry) else $error("carry");
   a_carryKeep: assert property (p_carryKeep) else $error("ck");
   a_pcLoad: assert property (p_pcLoad) else $error("pc load");
   a_pcStep: assert property (p_pcStep) else $error("pc step");
   a_spLoad: assert property (p_spLoad) else $error("sp");
   a_pcKeep: assert property (p_pcKeep) else $error("pc kept");
endmodule // cpurf_core_regs_chk

bind cpurf_core_regs cpurf_core_regs_chk chk_u (.clk(clk), .rst_b(rst_b),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
   .regRdStb(regRdStb), .regRdData(regRdData), .aluResult(aluResult),
   .aluCarry(aluCarry), .aluCarryEn(aluCarryEn), .aluZsEn(aluZsEn),
   .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .pcAdvance(pcAdvance),
   .pcStep(pcStep), .spLoad(spLoad), .spLoadValue(spLoadValue),
   .nextInstrAddr(nextInstrAddr), .stackPtr(stackPtr),
   .staticBase(staticBase), .carryFlag(carryFlag));

/* dv/cpurf_alu_model.sv */
// Adder-only model of the core ALU feeding the flag inputs.
// Assumes the bench holds operands and go for one clock per operation.
module cpurf_alu_model (
   input wire logic [31:0] opA,
   input wire logic [31:0] opB,
   input wire logic opGo,
   output logic [31:0] aluResult,
   output logic aluCarry,
   output logic aluCarryEn,
   output logic aluZsEn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Carry is the bit pushed past bit 31
   assign {aluCarry, aluResult} = {1'b0, opA} + {1'b0, opB};
   assign aluCarryEn = opGo;
   assign aluZsEn = opGo;
endmodule // cpurf_alu_model

/* dv/tb.sv */
// Self-checking bench of the core register file, random with corners.
// Assumes the hdl package and header are compiled first.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, regWrStb, regRdStb, pcLoad, pcAdvance, spLoad, opGo;
   logic [4:0] regAddr, a;
   logic [2:0] partSel, p, f;
   logic [3:0] pcStep;
   logic [31:0] regWrData, pcLoadValue, spLoadValue, opA, opB, aluResult;
   logic [31:0] regRdData, nextInstrAddr, stackPtr, staticBase, frameBase;
   logic [31:0] vectorBase, addrBase0, addrBase1, addrBase2, addrBase3;
   logic aluCarry, aluCarryEn, aluZsEn, carryFlag, zeroFlag, signFlag, uSel;
   logic [31:0] shadow [16];
   logic [31:0] seed, v;
   logic [32:0] sum;
   int errors, samplesChecked, cycles;
   cpurf_alu_model alu_u (.opA(opA), .opB(opB), .opGo(opGo),
      .aluResult(aluResult), .aluCarry(aluCarry), .aluCarryEn(aluCarryEn),
      .aluZsEn(aluZsEn));
   cpurf_core_regs dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regWrPart(cpurf_pkg::cpurf_part_t'(partSel)), .regRdData(regRdData),
      .aluResult(aluResult), .aluCarry(aluCarry), .aluCarryEn(aluCarryEn),
      .aluZsEn(aluZsEn), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
      .pcAdvance(pcAdvance), .pcStep(pcStep), .spLoad(spLoad),
      .spLoadValue(spLoadValue), .nextInstrAddr(nextInstrAddr),
      .stackPtr(stackPtr), .staticBase(staticBase), .frameBase(frameBase),
      .vectorBase(vectorBase), .addrBase0(addrBase0), .addrBase1(addrBase1),
      .addrBase2(addrBase2), .addrBase3(addrBase3), .carryFlag(carryFlag),
      .zeroFlag(zeroFlag), .signFlag(signFlag), .userStackSel(uSel));
   function automatic logic [31:0] nx(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Parts other than word only reach data words; bytes only the first two
   function automatic logic [31:0] mrg(logic [4:0] ad, logic [31:0] o,
      logic [31:0] d, logic [2:0] pt);
      if (ad > 5'h03 || pt == 3'h0) return d;
      if (pt == 3'h1) return {o[31:16], d[15:0]};
      if (pt == 3'h2) return {d[15:0], o[15:0]};
      if (ad > 5'h01) return o;
      o[8 * (pt - 3) +: 8] = d[7:0];
      return o;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      samplesChecked++;
      if (e !== g) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask
   task automatic wr(logic [4:0] ad, logic [31:0] d, logic [2:0] pt);
      @(posedge clk);
      {regWrStb, regAddr, regWrData, partSel} <= {1'b1, ad, d, pt};
      if (ad < 5'h0e) shadow[ad] = mrg(ad, shadow[ad], d, pt);
      @(posedge clk);
      regWrStb <= 1'b0;
   endtask
   task automatic rd(logic [4:0] ad, logic [31:0] e);
      @(posedge clk);
      {regRdStb, regAddr} <= {1'b1, ad};
      @(posedge clk);
      regRdStb <= 1'b0;
      #1 chk("read", e, regRdData);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         final_report;
      end
   end
   initial begin
      {regWrStb, regRdStb, pcLoad, pcAdvance, spLoad, opGo} = '0;
      {regAddr, regWrData, partSel, pcStep, pcLoadValue, spLoadValue} = '0;
      {opA, opB, rst_b} = '0;
      seed = 32'h76d2364c;
      for (int i = 0; i < 16; i++) shadow[i] = '0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 15; i++) rd(5'(i), 32'h0);
      for (int i = 0; i < 60; i++) begin
         seed = nx(seed);
         v = nx(seed);
         a = 5'(seed % 14);
         p = 3'(seed[15:8] % 7);
         if (a > 5'h0b) v[1:0] = 2'h0;
         wr(a, v, p);
         rd(a, shadow[a]);
      end
      for (int k = 0; k < 7; k++) begin
         wr(5'h00, 32'h13579bdf + k, 3'(k));
         wr(5'h02, 32'h2468ace0 + k, 3'(k));
         rd(5'h00, shadow[0]);
         rd(5'h02, shadow[2]);
      end
      chk("frame", shadow[9], frameBase);
      chk("vector", shadow[11], vectorBase);
      chk("addr", shadow[4] ^ shadow[5] ^ shadow[6] ^ shadow[7],
         addrBase0 ^ addrBase1 ^ addrBase2 ^ addrBase3);
      wr(5'h13, 32'hffffffff, 3'h0);
      rd(5'h13, 32'h0);
      wr(5'h0e, 32'h00000080, 3'h0);
      #1 chk("stack", shadow[12], stackPtr);
      chk("stack select", 32'h1, 32'(uSel));
      @(posedge clk);
      {spLoad, spLoadValue} <= {1'b1, 32'h00001ffc};
      @(posedge clk);
      spLoad <= 1'b0;
      shadow[12] = 32'h00001ffc;
      rd(5'h0f, shadow[12]);
      wr(5'h0f, 32'h00002ff0, 3'h0);
      shadow[12] = 32'h00002ff0;
      rd(5'h0c, shadow[12]);
      wr(5'h0e, 32'hfffffffd, 3'h0);
      rd(5'h0e, 32'h0000008d);
      wr(5'h0e, 32'h0000000d, 3'h0);
      #1 chk("stack", shadow[13], stackPtr);
      chk("stack select", 32'h0, 32'(uSel));
      for (int k = 0; k < 4; k++) begin
         seed = nx(seed);
         @(posedge clk);
         opA <= (k == 0) ? 32'h5 : (k == 1) ? 32'h7fffffff : seed;
         opB <= (k == 0) ? 32'hfffffffb : (k == 1) ? 32'h1 : nx(seed);
         opGo <= 1'b1;
         @(posedge clk);
         opGo <= 1'b0;
         sum = {1'b0, opA} + {1'b0, opB};
         #1 chk("carry", 32'(sum[32]), 32'(carryFlag));
         chk("zero", 32'(sum[31:0] == 0), 32'(zeroFlag));
         chk("sign", 32'(sum[31]), 32'(signFlag));
      end
      f = {sum[32], sum[31:0] == 0, sum[31]};
      wr(5'h01, 32'h0, 3'h0);
      rd(5'h0a, shadow[10]);
      chk("flags", 32'(f), 32'({carryFlag, zeroFlag, signFlag}));
      @(posedge clk);
      {pcLoad, pcLoadValue, pcAdvance, pcStep} <= {1'b1, 32'hfffffff8, 5'h1f};
      @(posedge clk);
      pcLoad <= 1'b0;
      @(posedge clk);
      pcStep <= 4'h4;
      @(posedge clk);
      pcAdvance <= 1'b0;
      rd(5'h0a, 32'hfffffff8 + 32'h13);
      final_report;
   end
endmodule // tb
